// [rtl/cfd_pkg.sv]
// Shared constants and types for the channel fault diagnosis block.
package cfd_pkg;

   // Sizes.
   localparam int NCH   = 3;
   localparam int SP_W  = 12;
   localparam int AW    = 8;

   // Register byte offsets; setpoint of channel k sits at ADDR_SETP + 4*k.
   localparam logic [AW-1:0] ADDR_CONFIG = 8'h00;
   localparam logic [AW-1:0] ADDR_SETP   = 8'h04;
   localparam logic [AW-1:0] ADDR_DIAG   = 8'h10;
   localparam logic [AW-1:0] ADDR_LIVE   = 8'h14;
   localparam logic [AW-1:0] SETP_STEP   = 8'h04;

   // Configuration fields.
   localparam int CFG_FM  = 0;
   localparam int CFG_FME = 3;
   localparam int CFG_SEL = 4;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;

   // Setpoint register fields.
   localparam int SETP_EN = 15;

   // Diagnosis word fields, each per-channel group NCH bits wide.
   localparam int D_OVC   = 0;
   localparam int D_OT    = 3;
   localparam int D_UV    = 6;
   localparam int D_OLSB  = 9;
   localparam int D_RE    = 12;
   localparam int D_PUMP_UNDERVOLTAGE_FLAG  = 15;
   localparam int D_OV    = 16;
   localparam int D_CRC   = 17;
   localparam int D_OFF_STATE_LOAD_FLAG = 18;

   // Live status word fields.
   localparam int L_LOCK  = 0;
   localparam int L_RUN   = 3;

   // Timing in system-clock cycles (or PWM periods for the regulator check).
   localparam int OCDT_CYC   = 30;
   localparam int OLSB_CYC   = 8192;
   localparam int RE_PWM     = 8;
   localparam int CAL_PERIOD = 100000;

   // Bus encodings.
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Analog monitor results of one channel.
   typedef struct packed {
      logic over_lim;
      logic over_temp;
      logic lsup_uv;
      logic below_olsb;
      logic load_cmp;
      logic integ_lim;
   } cfd_ch_in_t;

   // Device-wide monitor results and pins.
   typedef struct packed {
      logic ext_reset_n;
      logic en_pin;
      logic vdd_uv;
      logic clk_fault;
      logic wd_event;
      logic pump_uv;
      logic vbat_ov;
      logic crc_err;
      logic cal_ready;
   } cfd_glob_in_t;

   // Power-up sequencing states.
   typedef enum logic [1:0] {
      ST_BOOT = 2'h1,
      ST_RUN  = 2'h2
   } cfd_state_t;

endpackage

// [rtl/cfd_persist.sv]
// Persistence filter: flags a condition that holds for more than LIMIT ticks.
`timescale 1ns/10ps
`default_nettype none
module cfd_persist #(
   parameter int LIMIT = 8,
   parameter int CW    = $clog2(LIMIT + 2)
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Condition and counting enable.
   input  wire logic tick,
   input  wire logic cond,
   // Condition has persisted long enough.
   output logic      fire
);

   logic [CW-1:0] cnt_q;

   // Count only while the condition holds; any gap restarts the filter.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (!cond)
         cnt_q <= '0;
      else if (tick && cnt_q <= CW'(LIMIT))
         cnt_q <= cnt_q + 1'b1;
   end

   // Saturating compare keeps the result a level until the condition drops.
   assign fire = (cnt_q > CW'(LIMIT));

endmodule // cfd_persist
`default_nettype wire

// [rtl/cfd_top.sv]
// Fault supervision, diagnosis register and fault alert pin of the driver.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cfd_top #(
   parameter int OLSB_CYC   = cfd_pkg::OLSB_CYC,
   parameter int CAL_PERIOD = cfd_pkg::CAL_PERIOD
) (
   // Clock and reset.
   input  wire logic                                   REF_CLK,
   input  wire logic                                   NRST,
   // AHB-Lite slave.
   input  wire logic                                   HSEL,
   input  wire logic [31:0]                            HADDR,
   input  wire logic [1:0]                             HTRANS,
   input  wire logic                                   HWRITE,
   input  wire logic [2:0]                             HSIZE,
   input  wire logic [31:0]                            HWDATA,
   input  wire logic                                   HREADY,
   output logic [31:0]                                 HRDATA,
   output logic                                        HREADYOUT,
   output logic                                        HRESP,
   // Monitor inputs.
   input  wire cfd_pkg::cfd_ch_in_t [cfd_pkg::NCH-1:0] CH_IN,
   input  wire cfd_pkg::cfd_glob_in_t                  GLOB_IN,
   input  wire logic                                   PWM_TICK,
   // Channel controls.
   output logic [cfd_pkg::NCH-1:0]                     CH_DRIVE,
   output logic [cfd_pkg::NCH-1:0]                     DIAG_PU,
   output logic [cfd_pkg::NCH-1:0]                     DIAG_PD,
   output logic                                        CAL_REQ,
   // Open-drain fault alert pin.
   output logic                                        FAULT_ALERT_O,
   output logic                                        FAULT_ALERT_OE_N
);

   localparam int NCH = cfd_pkg::NCH;
   localparam int SPW = cfd_pkg::SP_W;

   cfd_pkg::cfd_glob_in_t g;
   cfd_pkg::cfd_state_t   state_q;
   logic [31:0]           cfg_q;
   logic                  en_q    [NCH];
   logic [SPW-1:0]        sp_q    [NCH];
   logic [NCH-1:0]        lock_q;
   logic [NCH-1:0]        op;
   logic [NCH-1:0]        ovc_hit, olsb_hit, re_hit, shut;
   logic [NCH-1:0]        ovc_q, ot_q, uv_q, olsb_q, re_q, off_state_load_flag;
   logic                  pump_undervoltage_flag_q, ov_q, crc_q;
   logic                  wr_pend_q;
   logic [7:0]            wr_addr_q;
   logic                  addr_go, rd_go, rd_diag;
   logic [31:0]           diag_word, rd_mux;
   logic                  alert_d;
   logic [16:0]           cal_cnt_q;

   assign g = GLOB_IN;

   ////////////////////////////////////////////////////////////////////////////
   // Bus front end.

   // A transfer is taken when the slave is selected and the bus is ready.
   assign addr_go = HSEL && HREADY && HTRANS[1];
   assign rd_go   = addr_go && !HWRITE;
   assign rd_diag = rd_go && HADDR[7:0] == cfd_pkg::ADDR_DIAG;

   // Diagnosis word as returned to software.
   always_comb
   begin
      diag_word = '0;
      diag_word[cfd_pkg::D_OVC +: NCH]   = ovc_q;
      diag_word[cfd_pkg::D_OT +: NCH]    = ot_q;
      diag_word[cfd_pkg::D_UV +: NCH]    = uv_q;
      diag_word[cfd_pkg::D_OLSB +: NCH]  = olsb_q;
      diag_word[cfd_pkg::D_RE +: NCH]    = re_q;
      diag_word[cfd_pkg::D_PUMP_UNDERVOLTAGE_FLAG]         = pump_undervoltage_flag_q;
      diag_word[cfd_pkg::D_OV]           = ov_q;
      diag_word[cfd_pkg::D_CRC]          = crc_q;
      diag_word[cfd_pkg::D_OFF_STATE_LOAD_FLAG +: NCH] = off_state_load_flag;
   end

   // Read decode; unmapped addresses read as zero.
   always_comb
   begin
      rd_mux = '0;
      case (HADDR[7:0])
         cfd_pkg::ADDR_CONFIG: rd_mux = cfg_q;
         cfd_pkg::ADDR_DIAG:   rd_mux = diag_word;
         cfd_pkg::ADDR_LIVE:
         begin
            rd_mux[cfd_pkg::L_LOCK +: NCH] = lock_q;
            rd_mux[cfd_pkg::L_RUN]         = (state_q == cfd_pkg::ST_RUN);
         end
         default:
         begin
            for (int k = 0; k < NCH; k++)
            begin
               if (HADDR[7:0] == cfd_pkg::ADDR_SETP + 8'(k) * cfd_pkg::SETP_STEP)
               begin
                  rd_mux[cfd_pkg::SETP_EN] = en_q[k];
                  rd_mux[SPW-1:0]          = sp_q[k];
               end
            end
         end
      endcase
   end

   // Read data is captured at the address phase so the data phase has no wait.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
         HRDATA <= '0;
      else if (rd_go)
         HRDATA <= rd_mux;
   end

   // Always ready and always OKAY.
   always_ff @(posedge REF_CLK)
   begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
   end

   // Writes land one cycle later, in the data phase, when HWDATA is valid.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end
      else
      begin
         wr_pend_q <= addr_go && HWRITE && HSIZE == cfd_pkg::HSIZE_WORD;
         wr_addr_q <= HADDR[7:0];
      end
   end

   // Configuration: channel masks, enable-pin mask, diagnostic current select.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
         cfg_q <= cfd_pkg::CFG_RST;
      else if (wr_pend_q && wr_addr_q == cfd_pkg::ADDR_CONFIG)
         cfg_q <= HWDATA;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-up sequencing and calibration reads.

   // Leaves boot once calibration has loaded; a logic-supply reset restarts it.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
         state_q <= cfd_pkg::ST_BOOT;
      else
         case (state_q)
            cfd_pkg::ST_BOOT: if (g.cal_ready && !g.vdd_uv) state_q <= cfd_pkg::ST_RUN;
            cfd_pkg::ST_RUN:  if (g.vdd_uv) state_q <= cfd_pkg::ST_BOOT;
            default:          state_q <= cfd_pkg::ST_BOOT;
         endcase
   end

   // Calibration reread request: once after reset, then every CAL_PERIOD cycles.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         cal_cnt_q <= '0;
         CAL_REQ   <= 1'b0;
      end
      else
      begin
         CAL_REQ   <= (cal_cnt_q == '0);
         cal_cnt_q <= (cal_cnt_q == 17'(CAL_PERIOD - 1)) ? '0 : cal_cnt_q + 1'b1;
      end
   end

   // CRC error only reports; channels are not touched.
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
         crc_q <= 1'b0;
      else
         crc_q <= g.crc_err | (crc_q & ~rd_diag);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Device-wide supply flags; a live condition re-sets at the clearing read.

   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         pump_undervoltage_flag_q <= 1'b0;
         ov_q   <= 1'b0;
      end
      else
      begin
         pump_undervoltage_flag_q <= g.pump_uv | (pump_undervoltage_flag_q & ~rd_diag);
         ov_q   <= g.vbat_ov | (ov_q & ~rd_diag);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel supervision.

   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      assign op[i] = en_q[i] && sp_q[i] != '0;

      // Overcurrent filter, window 20 to 40 cycles.
      cfd_persist #(.LIMIT(cfd_pkg::OCDT_CYC)) u_ovc (
         .clk   (REF_CLK),
         .rst_n (NRST),
         .tick  (1'b1),
         .cond  (CH_IN[i].over_lim && op[i]),
         .fire  (ovc_hit[i])
      );

      // Undercurrent while operating means open load or switch bypass.
      cfd_persist #(.LIMIT(OLSB_CYC)) u_olsb (
         .clk   (REF_CLK),
         .rst_n (NRST),
         .tick  (1'b1),
         .cond  (CH_IN[i].below_olsb && op[i]),
         .fire  (olsb_hit[i])
      );

      // Integrator pinned at a limit, counted in PWM periods.
      cfd_persist #(.LIMIT(cfd_pkg::RE_PWM)) u_re (
         .clk   (REF_CLK),
         .rst_n (NRST),
         .tick  (PWM_TICK),
         .cond  (CH_IN[i].integ_lim && op[i]),
         .fire  (re_hit[i])
      );

      // Every cause that switches this channel off.
      assign shut[i] = ovc_hit[i] | olsb_hit[i] | CH_IN[i].over_temp
                     | CH_IN[i].lsup_uv | g.pump_uv | g.vbat_ov;

      // Off-state comparator is passed through live, never stored.
      assign off_state_load_flag[i] = CH_IN[i].load_cmp && en_q[i] && sp_q[i] == '0;

      // Sticky flags: a set in the reading cycle wins over the clear.
      always_ff @(posedge REF_CLK)
      begin
         if (!NRST)
         begin
            ovc_q[i]  <= 1'b0;
            ot_q[i]   <= 1'b0;
            uv_q[i]   <= 1'b0;
            olsb_q[i] <= 1'b0;
            re_q[i]   <= 1'b0;
         end
         else
         begin
            ovc_q[i]  <= ovc_hit[i] | (ovc_q[i] & ~rd_diag);
            ot_q[i]   <= CH_IN[i].over_temp | (ot_q[i] & ~rd_diag);
            uv_q[i]   <= CH_IN[i].lsup_uv | (uv_q[i] & ~rd_diag);
            olsb_q[i] <= olsb_hit[i]
                       | (olsb_q[i] & ~(rd_diag & ~CH_IN[i].below_olsb));
            re_q[i]   <= re_hit[i] | (re_q[i] & ~rd_diag);
         end
      end

      // Lockout holds a shut channel off until the clearing read.
      always_ff @(posedge REF_CLK)
      begin
         if (!NRST)
            lock_q[i] <= 1'b0;
         else if (shut[i])
            lock_q[i] <= 1'b1;
         else if (rd_diag)
            lock_q[i] <= 1'b0;
      end

      // Enable and setpoint; a shutdown beats a concurrent write.
      always_ff @(posedge REF_CLK)
      begin
         if (!NRST)
         begin
            en_q[i] <= 1'b0;
            sp_q[i] <= '0;
         end
         else if (shut[i])
         begin
            en_q[i] <= 1'b0;
            sp_q[i] <= '0;
         end
         else if (wr_pend_q && !lock_q[i]
                  && wr_addr_q == cfd_pkg::ADDR_SETP + 8'(i) * cfd_pkg::SETP_STEP)
         begin
            en_q[i] <= HWDATA[cfd_pkg::SETP_EN];
            sp_q[i] <= HWDATA[SPW-1:0];
         end
      end

      // Drive and diagnostic current controls, registered.
      always_ff @(posedge REF_CLK)
      begin
         if (!NRST)
         begin
            CH_DRIVE[i] <= 1'b0;
            DIAG_PU[i]  <= 1'b0;
            DIAG_PD[i]  <= 1'b0;
         end
         else
         begin
            CH_DRIVE[i] <= op[i] && !shut[i];
            DIAG_PU[i]  <= en_q[i] && sp_q[i] == '0 && cfg_q[cfd_pkg::CFG_SEL + i];
            DIAG_PD[i]  <= en_q[i] && sp_q[i] == '0 && !cfg_q[cfd_pkg::CFG_SEL + i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault alert pin.

   // Gather every alerting cause; channel flags pass their mask gate.
   always_comb
   begin
      alert_d = (state_q != cfd_pkg::ST_RUN)
              | ~g.ext_reset_n | g.vdd_uv | g.clk_fault | g.wd_event
              | ov_q
              | (cfg_q[cfd_pkg::CFG_FME] & ~g.en_pin);
      for (int k = 0; k < NCH; k++)
         alert_d = alert_d | (cfg_q[cfd_pkg::CFG_FM + k]
                 & (ovc_q[k] | ot_q[k] | uv_q[k] | olsb_q[k]));
   end

   // Registered so a combinational glitch never reaches the pin; the pin
   // only ever pulls low, and at reset it already pulls.
   always_ff @(posedge REF_CLK)
   begin
      FAULT_ALERT_O <= 1'b0;
      if (!NRST)
         FAULT_ALERT_OE_N <= 1'b0;
      else
         FAULT_ALERT_OE_N <= ~alert_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!NRST);

   boot_alert_a: assert property (state_q == cfd_pkg::ST_BOOT |=> !FAULT_ALERT_OE_N)
      else $error("alert released during boot");

   alert_idle_a: assert property (!alert_d |=> FAULT_ALERT_OE_N && !FAULT_ALERT_O)
      else $error("alert pulled without cause");

   en_pin_a: assert property (cfg_q[cfd_pkg::CFG_FME] && !g.en_pin |=> !FAULT_ALERT_OE_N)
      else $error("enable pin low not alerted");

   ovc_shut_a: assert property (ovc_hit[0] |=> !en_q[0] && sp_q[0] == '0 && ovc_q[0])
      else $error("overcurrent did not shut channel");

   ovc_clear_a: assert property (rd_diag && ovc_q[0] && !ovc_hit[0] |=> !ovc_q[0])
      else $error("overcurrent flag not cleared by read");

   lock_off_a: assert property (lock_q[0] && !$past(rd_diag) |-> !op[0])
      else $error("locked channel operating");

   diag_pu_a: assert property (en_q[2] && sp_q[2] == '0 && cfg_q[cfd_pkg::CFG_SEL + 2]
                               |=> DIAG_PU[2] && !DIAG_PD[2])
      else $error("pull-up current not switched on");

   pump_all_a: assert property (g.pump_uv |=> !en_q[0] && !en_q[1] && !en_q[2] && pump_undervoltage_flag_q)
      else $error("pump undervoltage left channel enabled");

endmodule // cfd_top
`default_nettype wire

// [verif/cfd_host_model.sv]
// Host-side model of the shared open-drain fault alert line.
`timescale 1ns/10ps
`default_nettype none
module cfd_host_model (
   // Alert pin of the device under test.
   input  wire logic alert_o,
   input  wire logic alert_oe_n,
   // Another device on the same line, low = pulling.
   input  wire logic other_pull_n,
   // Resolved line as the host interrupt input sees it.
   output logic      alert_line
);
   // The pull-up wins unless some party pulls; an active-high drive is never honoured.
   assign alert_line = ((!alert_oe_n && !alert_o) || !other_pull_n) ? 1'b0 : 1'b1;
endmodule // cfd_host_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench for the channel fault diagnosis block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic                                   REF_CLK = 1'b0;
   logic                                   NRST = 1'b0;
   logic                                   HSEL = 1'b0;
   logic [31:0]                            HADDR = 32'h0;
   logic [1:0]                             HTRANS = 2'h0;
   logic                                   HWRITE = 1'b0;
   logic [2:0]                             HSIZE = 3'h2;
   logic [31:0]                            HWDATA = 32'h0;
   logic [31:0]                            HRDATA;
   logic                                   HREADYOUT;
   logic                                   HRESP;
   cfd_pkg::cfd_ch_in_t [cfd_pkg::NCH-1:0] ch_in = '0;
   cfd_pkg::cfd_glob_in_t                  glob_in = 9'h180;
   logic                                   pwm_tick = 1'b0;
   logic [1:0]                             pwm_cnt = 2'h0;
   logic [cfd_pkg::NCH-1:0]                ch_drive;
   logic [cfd_pkg::NCH-1:0]                diag_pu;
   logic [cfd_pkg::NCH-1:0]                diag_pd;
   logic                                   cal_req;
   logic                                   alert_o;
   logic                                   alert_oe_n;
   logic                                   other_pull_n = 1'b1;
   logic                                   alert_line;
   logic [31:0]                            rd;
   int                                     errors = 0;
   int                                     n_tests = 0;

   // Small counts keep the run short; expectations use these same values.
   cfd_top #(.OLSB_CYC(16), .CAL_PERIOD(64)) u_cfd_top (
      .REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CH_IN(ch_in),
      .GLOB_IN(glob_in), .PWM_TICK(pwm_tick), .CH_DRIVE(ch_drive), .DIAG_PU(diag_pu),
      .DIAG_PD(diag_pd), .CAL_REQ(cal_req), .FAULT_ALERT_O(alert_o),
      .FAULT_ALERT_OE_N(alert_oe_n));

   cfd_host_model u_cfd_host_model (.alert_o(alert_o), .alert_oe_n(alert_oe_n),
      .other_pull_n(other_pull_n), .alert_line(alert_line));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock at 200 MHz.
   always #2.5 REF_CLK = ~REF_CLK;

   // One PWM period every four clocks, so the regulator filter counts quickly.
   always @(posedge REF_CLK)
   begin
      pwm_cnt <= pwm_cnt + 2'h1;
      pwm_tick <= (pwm_cnt == 2'h3);
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask

   task automatic print_verdict();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One AHB-Lite single word transfer; the address phase is held until hready is seen.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      HSIZE <= cfd_pkg::HSIZE_WORD;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(nm, exp, rd);
      check("hresp", 32'h0, 32'(HRESP));
   endtask

   task automatic setp(input int k, input logic [11:0] sp);
      bus(1'b1, cfd_pkg::ADDR_SETP + 8'(4 * k), 32'(sp) | (32'h1 << cfd_pkg::SETP_EN));
   endtask

   task automatic alert(input logic exp);
      check("alert_oe_n", 32'(exp), 32'(alert_oe_n));
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Cuts a hang short; the tests need well under ten thousand cycles.
   initial
   begin
      #100000;
      errors++;
      print_verdict();
   end

   initial
   begin
      cyc(8);
      alert(1'b0);
      NRST <= 1'b1;
      cyc(10);
      alert(1'b0);
      glob_in.cal_ready <= 1'b1;
      cyc(6);
      alert(1'b1);
      rdchk("config", cfd_pkg::ADDR_CONFIG, cfd_pkg::CFG_RST);
      rdchk("unmapped", 8'h20, 32'h0);
      // Enable pin gating of the alert, off then on.
      bus(1'b1, cfd_pkg::ADDR_CONFIG, 32'h1);
      glob_in.en_pin <= 1'b0;
      cyc(4);
      alert(1'b1);
      bus(1'b1, cfd_pkg::ADDR_CONFIG, 32'h9);
      cyc(4);
      alert(1'b0);
      glob_in.en_pin <= 1'b1;
      cyc(4);
      alert(1'b1);
      // Overcurrent on channel 0: filtered, shuts down, locks until read.
      setp(0, 12'h064);
      cyc(3);
      check("drive", 32'h1, 32'(ch_drive));
      ch_in[0].over_lim <= 1'b1;
      cyc(19);
      check("drive", 32'h1, 32'(ch_drive));
      cyc(25);
      check("drive", 32'h0, 32'(ch_drive));
      alert(1'b0);
      ch_in[0].over_lim <= 1'b0;
      setp(0, 12'h064);
      cyc(3);
      check("drive", 32'h0, 32'(ch_drive));
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h0);
      cyc(3);
      alert(1'b1);
      setp(0, 12'h064);
      cyc(3);
      check("drive", 32'h1, 32'(ch_drive));
      // Overtemperature on channel 1 with its mask clear.
      setp(1, 12'h040);
      cyc(3);
      ch_in[1].over_temp <= 1'b1;
      cyc(4);
      check("drive", 32'h1, 32'(ch_drive));
      alert(1'b1);
      ch_in[1].over_temp <= 1'b0;
      cyc(2);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1 << (cfd_pkg::D_OT + 1));
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h0);
      // Calibration CRC error and a regulation error while channel 0 runs.
      glob_in.crc_err <= 1'b1;
      cyc(1);
      glob_in.crc_err <= 1'b0;
      ch_in[0].integ_lim <= 1'b1;
      cyc(60);
      ch_in[0].integ_lim <= 1'b0;
      cyc(2);
      check("drive", 32'h1, 32'(ch_drive));
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1 << 17 | 32'h1 << 12);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h0);
      // Pump undervoltage stops all channels; flag stays while present.
      glob_in.pump_uv <= 1'b1;
      cyc(4);
      check("drive", 32'h0, 32'(ch_drive));
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1 << 15);
      glob_in.pump_uv <= 1'b0;
      cyc(2);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1 << 15);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h0);
      setp(0, 12'h064);
      cyc(3);
      check("drive", 32'h1, 32'(ch_drive));
      // Off-state diagnostics on channel 2: pull-up first, then pull-down.
      bus(1'b1, cfd_pkg::ADDR_CONFIG, 32'h4d);
      setp(2, 12'h000);
      cyc(3);
      check("pu_pd", 32'h2, 32'({diag_pu[2], diag_pd[2]}));
      ch_in[2].load_cmp <= 1'b1;
      cyc(3);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1 << (cfd_pkg::D_OFF_STATE_LOAD_FLAG + 2));
      ch_in[2].load_cmp <= 1'b0;
      cyc(3);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h0);
      bus(1'b1, cfd_pkg::ADDR_CONFIG, 32'h0d);
      cyc(20);
      check("pu_pd", 32'h1, 32'({diag_pu[2], diag_pd[2]}));
      setp(2, 12'h020);
      cyc(3);
      check("pu_pd", 32'h0, 32'({diag_pu[2], diag_pd[2]}));
      // Open load or bypass on channel 2 while it operates.
      ch_in[2].below_olsb <= 1'b1;
      cyc(12);
      check("drive", 32'h5, 32'(ch_drive));
      cyc(18);
      check("drive", 32'h1, 32'(ch_drive));
      alert(1'b0);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1 << (cfd_pkg::D_OLSB + 2));
      ch_in[2].below_olsb <= 1'b0;
      cyc(2);
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h1 << (cfd_pkg::D_OLSB + 2));
      rdchk("diag", cfd_pkg::ADDR_DIAG, 32'h0);
      cyc(3);
      alert(1'b1);
      // Wired-AND: another device pulls the shared line.
      other_pull_n <= 1'b0;
      cyc(2);
      check("line", 32'h0, 32'(alert_line));
      check("alert_o", 32'h0, 32'(alert_o));
      other_pull_n <= 1'b1;
      // Calibration reread request repeats once per calibration period.
      do cyc(1); while (cal_req !== 1'b1);
      cyc(64);
      check("cal_req", 32'h1, 32'(cal_req));
      cyc(1);
      check("cal_req", 32'h0, 32'(cal_req));
      // Device-wide causes: watchdog, clock fault, supply reset, reset pin.
      for (int k = 0; k < $bits(glob_in); k++)
      begin
         if (k == 4 || k == 5 || k == 6 || k == 8)
         begin
            glob_in <= glob_in ^ (9'h1 << k);
            cyc(4);
            alert(1'b0);
            glob_in <= glob_in;
            cyc(1);
            glob_in[k] <= ~glob_in[k];
            cyc(6);
            alert(1'b1);
         end
      end
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
